// ---- sram_spi_pkg.sv ----
package sram_spi_pkg;
  // Instruction codes
  localparam logic [7:0] INSTR_READ        = 8'h03;
  localparam logic [7:0] INSTR_WRITE       = 8'h02;
  localparam logic [7:0] STATUS_READ_INSTR  = 8'h05;
  localparam logic [7:0] STATUS_WRITE_INSTR = 8'h01;
  // Status register layout
  localparam int         MODE_HI_BIT    = 7;
  localparam int         MODE_LO_BIT    = 6;
  localparam int         PAUSE_DIS_BIT  = 0;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'hC1;
  // Mode encodings
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_SEQ  = 2'h1;
  // Array geometry
  localparam int          ADDR_W     = 15;
  localparam int          MEM_DEPTH  = 32768;
  localparam int          PAGE_W     = 5;
  localparam logic [14:0] ADDR_TOP   = 15'h7FFF;
  localparam logic [14:0] ADDR_ZERO  = 15'h0000;
  // Field lengths in serial clocks
  localparam logic [4:0]  ADDR_BITS  = 5'h10;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  // Write buffer
  localparam int          FIFO_W     = 23;
  localparam int          FIFO_DEPTH = 8;
endpackage

// ---- sync_edge.sv ----
`timescale 1ns/10ps
// Two-flop synchroniser for one pin
module sync_edge #(
  parameter logic RST_VAL = 1'b1  // Idle level of the pin
) (
  input  wire logic i_ref_clk,  // System clock
  input  wire logic i_nrst,     // Async reset, active low
  input  wire logic i_ce,       // Clock enable
  input  wire logic i_pin,      // Asynchronous pin
  output logic      o_sync      // Synchronised level
);
  logic meta;

  // First flop feeds only the second; reset to idle level, no false edge
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end else if (i_ce) begin
      meta   <= i_pin;
      o_sync <= meta;
    end
  end
endmodule

// ---- write_fifo.sv ----
`timescale 1ns/10ps
// Small synchronous FIFO with valid/ready on both sides
module write_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,  // System clock
  input  wire logic             i_nrst,     // Async reset, active low
  input  wire logic             i_ce,       // Clock enable
  input  wire logic             i_valid,    // Write side valid
  output logic                  o_ready,    // Write side ready
  input  wire logic [WIDTH-1:0] i_data,     // Write data
  output logic                  o_valid,    // Read side valid
  input  wire logic             i_ready,    // Read side ready
  output logic      [WIDTH-1:0] o_data      // Read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = store[rd_ptr];
  assign push    = i_ce & i_valid & o_ready;
  assign pop     = i_ce & o_valid & i_ready;

  // Storage array
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      store[wr_ptr] <= i_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + push - pop);
    end
  end
endmodule

// ---- serial_sram_spi_slave.sv ----
`timescale 1ns/10ps
module serial_sram_spi_slave (
  input  wire logic i_ref_clk,   // System clock, 250 MHz
  input  wire logic i_nrst,      // Async reset, active low
  input  wire logic i_ce,        // Clock enable, freezes all state
  input  wire logic i_cs_n,      // Chip select pin, active low
  input  wire logic i_sck,       // Serial clock pin
  input  wire logic i_si,        // Serial data input pin
  input  wire logic i_pause_n,   // Pause pin, active low
  output logic      o_so,        // Serial data output
  output logic      o_so_oe_n,   // Output enable, low drives
  output logic      o_busy       // Write buffer not empty
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_INSTR  = 3'b001,
    ST_ADDR   = 3'b010,
    ST_RDATA  = 3'b011,
    ST_WDATA  = 3'b100,
    ST_SRD    = 3'b101,
    ST_SWR    = 3'b110,
    ST_IGNORE = 3'b111
  } phase_e;

  logic        cs_s;
  logic        sck_s;
  logic        si_s;
  logic        pause_s;
  logic        sck_d;
  logic        cs_d;
  logic        paused;
  logic        sck_rise;
  logic        sck_fall;
  logic        active;
  phase_e      phase;
  logic [7:0]  shift_in;
  logic [2:0]  bit_cnt;
  logic [4:0]  addr_cnt;
  logic        is_read;
  logic        byte_done;
  logic [14:0] addr;
  logic [7:0]  status;
  logic [7:0]  out_byte;
  logic        out_drive;
  logic [7:0]  mem [sram_spi_pkg::MEM_DEPTH];
  logic [7:0]  next_byte_in;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        fifo_out_valid;
  logic [22:0] fifo_out_data;
  logic [22:0] fifo_in_data;
  logic        take_bit;

  // Operating mode field of the status register
  function automatic logic [1:0] op_mode(input logic [7:0] s);
    return s[sram_spi_pkg::MODE_HI_BIT:sram_spi_pkg::MODE_LO_BIT];
  endfunction

  // Next address by operating mode
  function automatic logic [14:0] next_addr(input logic [14:0] a, input logic [1:0] mode);
    logic [14:0] r;
    r = a;
    unique case (mode)
      sram_spi_pkg::MODE_PAGE: r = {a[14:5], 5'(a[4:0] + 1'b1)};
      sram_spi_pkg::MODE_SEQ: r = (a == sram_spi_pkg::ADDR_TOP) ? sram_spi_pkg::ADDR_ZERO
                                                                 : 15'(a + 1'b1);
      default: r = a;
    endcase
    return r;
  endfunction

  // Pin synchronisers
  // Chip select idles high
  sync_edge #(
    .RST_VAL (1'b1)
  ) u_sync_cs (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_pin     (i_cs_n),
    .o_sync    (cs_s)
  );
  // Serial clock idles low
  sync_edge #(
    .RST_VAL (1'b0)
  ) u_sync_sck (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_pin     (i_sck),
    .o_sync    (sck_s)
  );
  // Serial input idles low
  sync_edge #(
    .RST_VAL (1'b0)
  ) u_sync_si (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_pin     (i_si),
    .o_sync    (si_s)
  );
  // Pause pin idles high
  sync_edge #(
    .RST_VAL (1'b1)
  ) u_sync_pause (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_pin     (i_pause_n),
    .o_sync    (pause_s)
  );

  // Edge detection history
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else if (i_ce) begin
      sck_d <= sck_s;
      cs_d  <= cs_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign active   = ~cs_s;

  // Pause tracking
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      paused <= 1'b0;
    end else if (i_ce) begin
      if (cs_s || status[sram_spi_pkg::PAUSE_DIS_BIT]) begin
        paused <= 1'b0;
      end else if (!paused && !pause_s && (sck_fall || (!sck_s && !sck_d))) begin
        paused <= 1'b1;
      end else if (paused && pause_s && !sck_s) begin
        paused <= 1'b0;
      end
    end
  end

  // Shift input, byte end, one taken bit per rise
  assign next_byte_in = {shift_in[6:0], si_s};
  assign byte_done    = (bit_cnt == sram_spi_pkg::LAST_BIT);
  assign fifo_in_data = {addr, next_byte_in};
  assign take_bit     = active && !paused && sck_rise && !(phase == ST_WDATA && !fifo_ready);

  // Transfer sequencer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase    <= ST_IDLE;
      shift_in <= 8'h00;
      bit_cnt  <= 3'h0;
      addr_cnt <= 5'h00;
      is_read  <= 1'b0;
      addr     <= 15'h0000;
    end else if (i_ce) begin
      if (!active) begin
        phase   <= ST_IDLE;
        bit_cnt <= 3'h0;
      end else if (phase == ST_IDLE) begin
        // start only on select falling edge
        if (cs_d) begin
          phase    <= ST_INSTR;
          bit_cnt  <= 3'h0;
          addr_cnt <= 5'h00;
        end
      end else if (take_bit) begin
        shift_in <= next_byte_in;
        bit_cnt  <= 3'(bit_cnt + 1'b1);
        unique case (phase)
          ST_INSTR: begin
            if (byte_done) begin
              unique case (next_byte_in)
                sram_spi_pkg::INSTR_READ: begin
                  phase   <= ST_ADDR;
                  is_read <= 1'b1;
                end
                sram_spi_pkg::INSTR_WRITE: begin
                  phase   <= ST_ADDR;
                  is_read <= 1'b0;
                end
                sram_spi_pkg::STATUS_READ_INSTR:  phase <= ST_SRD;
                sram_spi_pkg::STATUS_WRITE_INSTR: phase <= ST_SWR;
                default:                          phase <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addr     <= {addr[13:0], si_s};
            addr_cnt <= 5'(addr_cnt + 1'b1);
            if (addr_cnt == 5'(sram_spi_pkg::ADDR_BITS - 1'b1)) begin
              phase <= is_read ? ST_RDATA : ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (byte_done) begin
              if (op_mode(status) == sram_spi_pkg::MODE_BYTE) begin
                phase <= ST_IGNORE;
              end
              addr <= next_addr(addr, op_mode(status));
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              if (op_mode(status) == sram_spi_pkg::MODE_BYTE) begin
                phase <= ST_IGNORE;
              end
              addr <= next_addr(addr, op_mode(status));
            end
          end
          ST_SRD: begin
            if (byte_done) begin
              phase <= ST_IGNORE;
            end
          end
          ST_SWR: begin
            if (byte_done) begin
              phase <= ST_IGNORE;
            end
          end
          ST_IDLE, ST_IGNORE: begin
            // Nothing more is taken until deselect
            bit_cnt <= bit_cnt;
          end
        endcase
      end
    end
  end

  assign fifo_valid = take_bit && (phase == ST_WDATA) && byte_done;

  // Completed write bytes wait here for the array
  write_fifo #(
    .WIDTH (sram_spi_pkg::FIFO_W),
    .DEPTH (sram_spi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_valid   (fifo_valid),
    .o_ready   (fifo_ready),
    .i_data    (fifo_in_data),
    .o_valid   (fifo_out_valid),
    .i_ready   (~(active && phase == ST_RDATA)),
    .o_data    (fifo_out_data)
  );

  // Array storage, drained from the buffer
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && fifo_out_valid && !(active && phase == ST_RDATA)) begin
      mem[fifo_out_data[22:8]] <= fifo_out_data[7:0];
    end
  end

  // Status register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status <= sram_spi_pkg::STATUS_RESET;
    end else if (i_ce && take_bit && phase == ST_SWR && byte_done) begin
      status <= next_byte_in & sram_spi_pkg::STATUS_WR_MASK;
    end
  end

  // Output byte load and shift
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_byte  <= 8'h00;
      out_drive <= 1'b0;
      o_so      <= 1'b0;
    end else if (i_ce) begin
      if (!active) begin
        out_drive <= 1'b0;
      end else if (!paused && sck_fall) begin
        if (bit_cnt == 3'h0 && (phase == ST_RDATA || phase == ST_SRD)) begin
          out_byte  <= (phase == ST_SRD) ? {status[6:0], 1'b0} : {mem[addr][6:0], 1'b0};
          o_so      <= (phase == ST_SRD) ? status[7] : mem[addr][7];
          out_drive <= 1'b1;
        end else if (phase == ST_RDATA || phase == ST_SRD) begin
          o_so     <= out_byte[7];
          out_byte <= {out_byte[6:0], 1'b0};
        end else begin
          out_drive <= 1'b0;
        end
      end
    end
  end

  // Output enable, busy flag
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_so_oe_n <= 1'b1;
      o_busy    <= 1'b0;
    end else if (i_ce) begin
      o_so_oe_n <= ~(active && out_drive && !paused && pause_s);
      o_busy    <= fifo_out_valid;
    end
  end
endmodule

// ---- sram_spi_chk.sv ----
`timescale 1ns/10ps
// Pin checks on the serial slave
module sram_spi_chk (
  input wire logic i_ref_clk, // Clock
  input wire logic i_nrst,    // Reset
  input wire logic i_ce,      // Enable
  input wire logic i_cs_n,    // Select
  input wire logic i_sck,     // Serial clock
  input wire logic i_si,      // Serial in
  input wire logic i_pause_n, // Pause
  input wire logic o_so,      // Serial out
  input wire logic o_so_oe_n, // Out enable
  input wire logic o_busy     // Buffer busy
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Steps of deselect, pause and clock high
  sequence s_desel;
    $rose(i_cs_n) ##1 i_cs_n[*4];
  endsequence
  sequence s_paused;
    (i_ce && !i_pause_n)[*5];
  endsequence
  sequence s_sck_high;
    (i_ce && i_sck && !i_cs_n && i_pause_n)[*4];
  endsequence
  property p_reset_out;
    $rose(i_nrst) |-> o_so_oe_n && !o_busy;
  endproperty
  property p_desel_hiz;
    s_desel |-> o_so_oe_n;
  endproperty
  property p_desel_bound;
    $rose(i_cs_n) |-> ##[1:6] o_so_oe_n;
  endproperty
  property p_pause_hiz;
    s_paused |-> o_so_oe_n;
  endproperty
  property p_so_fall_only;
    s_sck_high |-> $stable(o_so);
  endproperty
  property p_oe_after_fall;
    $fell(o_so_oe_n) |-> !$past(i_sck, 2) && !i_cs_n;
  endproperty
  property p_busy_from_write;
    $rose(o_busy) |-> !$past(i_cs_n, 3);
  endproperty
  property p_busy_drains;
    $rose(o_busy) |-> ##[1:200] !o_busy;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle after reset");
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("output driven while deselected");
  a_desel_bound: assert property (p_desel_bound)
    else $error("output not released after deselect");
  a_pause_hiz: assert property (p_pause_hiz)
    else $error("output driven while paused");
  a_so_fall_only: assert property (p_so_fall_only)
    else $error("output changed with clock high");
  a_oe_after_fall: assert property (p_oe_after_fall)
    else $error("output enabled without clock fall");
  a_busy_from_write: assert property (p_busy_from_write)
    else $error("buffer filled while deselected");
  a_busy_drains: assert property (p_busy_drains)
    else $error("buffer never drained");
endmodule

bind serial_sram_spi_slave sram_spi_chk chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .i_pause_n(i_pause_n), .o_so(o_so),
  .o_so_oe_n(o_so_oe_n), .o_busy(o_busy));

// ---- spi_host_model.sv ----
`timescale 1ns/10ps
// Host master on the serial pins
module spi_host_model (
  input  wire logic i_ref_clk, // Clock
  input  wire logic i_so,      // Serial out
  input  wire logic i_so_oe_n, // Out enable
  output logic      o_cs_n,    // Select
  output logic      o_sck,     // Serial clock
  output logic      o_si,      // Serial in
  output logic      o_pause_n  // Pause
);
  logic so_last;
  logic so_w;
  int   drv;
  // Released line shows inverse of last level
  always_ff @(posedge i_ref_clk) if (!i_so_oe_n) so_last <= i_so;
  assign so_w = i_so_oe_n ? ~so_last : i_so;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_pause_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic sel(input logic on);
    o_sck <= 1'b0;
    wt(8);
    o_cs_n <= ~on;
    drv = on ? 0 : drv;
    wt(8);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck <= 1'b0;
      o_si <= tx[i];
      wt(4);
      o_sck <= 1'b1;
      wt(3);
      rx[i] = so_w;
      if (i_so_oe_n === 1'b0) drv++;
      wt(1);
    end
  endtask
  // pause and resume with clock low
  task automatic hold_for(output logic hz);
    o_sck <= 1'b0;
    wt(4);
    o_pause_n <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wt(4);
      o_sck <= ~o_sck;
      o_si <= ~o_si;
    end
    hz = i_so_oe_n;
    wt(4);
    o_pause_n <= 1'b1;
    wt(4);
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        i_ref_clk;
  logic        i_nrst;
  logic        i_ce;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        pause_n;
  logic        so;
  logic        so_oe_n;
  logic        busy;
  logic        hz;
  logic [31:0] got;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // Clock, design and host
  initial i_ref_clk = 1'b0;
  always #2 i_ref_clk = ~i_ref_clk;
  serial_sram_spi_slave dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_pause_n(pause_n), .o_so(so), .o_so_oe_n(so_oe_n), .o_busy(busy));
  spi_host_model host (.i_ref_clk(i_ref_clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si), .o_pause_n(pause_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      wrap_up();
    end
  end
  // One frame; array codes and unknown codes with bit 1 set carry an address
  task automatic frame(input logic [7:0] ins, input logic [15:0] a, input int n,
                       input logic [31:0] d, input logic hold);
    logic [7:0] b;
    got = 32'h0;
    host.sel(1'b1);
    host.xfer(ins, b);
    if (ins[1]) begin
      host.xfer(a[15:8], b);
      host.xfer(a[7:0], b);
      if (hold) begin
        host.hold_for(hz);
        check(hz, 32'h1);
      end
    end
    for (int i = 0; i < n; i++) begin
      host.xfer(d[31-8*i -: 8], b);
      got = {got[23:0], b};
    end
    host.sel(1'b0);
    for (int k = 0; k < 300 && busy !== 1'b0; k++)
      @(posedge i_ref_clk);
    check(busy, 32'h0);
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [31:0] d);
    frame(sram_spi_pkg::INSTR_WRITE, a, n, d, 1'b0);
  endtask
  task automatic rd(input logic [15:0] a, input int n, input logic hold);
    frame(sram_spi_pkg::INSTR_READ, a, n, 32'h0, hold);
  endtask
  task automatic st_wr(input logic [7:0] v);
    frame(sram_spi_pkg::STATUS_WRITE_INSTR, 16'h0, 1, {v, 24'h0}, 1'b0);
  endtask
  task automatic st_rd();
    frame(sram_spi_pkg::STATUS_READ_INSTR, 16'h0, 1, 32'h0, 1'b0);
  endtask
  task automatic t_status();
    logic [7:0] v [4] = '{8'h00, 8'h80, 8'h40, 8'h01};
    st_wr(8'hFF);
    st_rd();
    check(got, 32'hC1);
    foreach (v[i]) begin
      st_wr(v[i] | 8'h3E);
      st_rd();
      check(got, {24'h0, v[i]});
    end
    // Clock enable low: a status write must not land
    i_ce <= 1'b0;
    st_wr(8'h80);
    i_ce <= 1'b1;
    st_rd();
    check(got, 32'h01);
    $display("status test done");
  endtask
  task automatic t_byte();
    st_wr(8'h00);
    wr(16'h0124, 1, 32'h11000000);
    wr(16'h8123, 2, 32'hA53C0000);
    rd(16'h0123, 1, 1'b0);
    check(got, 32'hA5);
    rd(16'h0124, 1, 1'b0);
    check(got, 32'h11);
    $display("byte test done");
  endtask
  task automatic t_page();
    st_wr(8'h80);
    wr(16'h041E, 4, 32'h1E1F2021);
    rd(16'h041F, 3, 1'b0);
    check(got, 32'h1F2021);
    $display("page test done");
  endtask
  task automatic t_seq();
    st_wr(8'h40);
    wr(16'h0001, 1, 32'h77000000);
    wr(16'h7FFF, 2, 32'h5AC30000);
    rd(16'hFFFF, 3, 1'b0);
    check(got, 32'h5AC377);
    $display("sequential test done");
  endtask
  task automatic t_pause();
    st_wr(8'h00);
    rd(16'h0123, 1, 1'b1);
    check(got, 32'hA5);
    $display("pause test done");
  endtask
  task automatic t_unknown();
    frame(8'hFF, 16'h0123, 2, 32'hEEEE0000, 1'b0);
    check(host.drv, 32'h0);
    rd(16'h0123, 1, 1'b0);
    check(got, 32'hA5);
    st_rd();
    check(got, 32'h0);
    $display("unknown code test done");
  endtask
  // Reset, then scenarios
  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    t_status();
    t_byte();
    t_page();
    t_seq();
    t_pause();
    t_unknown();
    wrap_up();
  end
endmodule
